// file: pkg/sadc_regs.svh
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH

// Register offsets on the plain register port
`define SADC_OFF_MAIN        3'h0
`define SADC_OFF_CFG         3'h1
`define SADC_OFF_RESULT      3'h2
`define SADC_OFF_FLAG        3'h3

// Main control register fields
`define SADC_MAIN_ON_BIT     0
`define SADC_MAIN_GO_BIT     1
`define SADC_MAIN_CHS_LSB    2
`define SADC_MAIN_CHS_MSB    5

// Clock and reference register fields
`define SADC_CFG_REF_LSB     0
`define SADC_CFG_REF_MSB     1
`define SADC_CFG_CLK_LSB     4
`define SADC_CFG_CLK_MSB     6

// Flag register fields
`define SADC_FLAG_DONE_BIT   0
`define SADC_FLAG_IRQ_EN_BIT 1

// Reset values
`define SADC_RST_BYTE        8'h00

// Timing counts
`define SADC_TAD_LAST        4'h9
`define SADC_START_DELAY_CYC 3'h4
`define SADC_CLK_RC          2'h3
`define SADC_FIRST_TRIAL     8'h80

// Bit-period divider terminal counts per clock-select code
`define SADC_DIV2_LAST       6'h01
`define SADC_DIV8_LAST       6'h07
`define SADC_DIV32_LAST      6'h1f
`define SADC_DIV4_LAST       6'h03
`define SADC_DIV16_LAST      6'h0f
`define SADC_DIV64_LAST      6'h3f

`endif

// file: pkg/sadc_pkg.sv
package sadc_pkg;

  // Sequencer states of the approximation engine
  typedef enum logic [1:0]
  {
    SADC_IDLE  = 2'b00,
    SADC_DELAY = 2'b01,
    SADC_CONV  = 2'b10
  } sadc_state_e;

  typedef logic [7:0] sadc_byte_t;

endpackage : sadc_pkg

// file: pkg/sadc_sar_if.sv
`timescale 1ns/1ns
interface sadc_sar_if;
  logic                start;
  logic                abort;
  logic                rc_mode;
  logic                tad_tick;
  logic                comp;
  logic                busy;
  logic                done;
  sadc_pkg::sadc_byte_t result;
  sadc_pkg::sadc_byte_t code;

  modport ctl (output start, abort, rc_mode, tad_tick, comp,
               input  busy, done, result, code);
  modport sar (input  start, abort, rc_mode, tad_tick, comp,
               output busy, done, result, code);
endinterface : sadc_sar_if

// file: core/sadc_sar.sv
`timescale 1ns/1ns
`include "sadc_regs.svh"
module sadc_sar
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  sadc_sar_if.sar  link
);
  sadc_pkg::sadc_state_e state_reg, state_next;
  logic [3:0]            tad_reg, tad_next;
  logic [2:0]            dly_reg, dly_next;
  sadc_pkg::sadc_byte_t  code_reg, code_next;
  sadc_pkg::sadc_byte_t  mask_reg, mask_next;
  sadc_pkg::sadc_byte_t  result_reg, result_next;
  logic                  done_reg, done_next;

  // Engine status toward the control side
  assign link.busy   = (state_reg != sadc_pkg::SADC_IDLE);
  assign link.done   = done_reg;
  assign link.result = result_reg;
  assign link.code   = code_reg;

  // Sequencer: optional start delay, then ten bit periods
  always_comb
  begin
    state_next  = state_reg;
    tad_next    = tad_reg;
    dly_next    = dly_reg;
    code_next   = code_reg;
    mask_next   = mask_reg;
    result_next = result_reg;
    done_next   = 1'b0;
    case (state_reg)
      sadc_pkg::SADC_IDLE:
        if (link.start)
        begin
          code_next  = `SADC_RST_BYTE;
          mask_next  = `SADC_RST_BYTE;
          tad_next   = 4'h0;
          dly_next   = 3'h0;
          state_next = link.rc_mode ? sadc_pkg::SADC_DELAY : sadc_pkg::SADC_CONV;
        end
      sadc_pkg::SADC_DELAY:
        if (dly_reg == `SADC_START_DELAY_CYC - 3'h1)
          state_next = sadc_pkg::SADC_CONV;
        else
          dly_next = dly_reg + 3'h1;
      sadc_pkg::SADC_CONV:
        if (link.tad_tick)
        begin
          tad_next = tad_reg + 4'h1;
          if (tad_reg == 4'h0)
          begin
            code_next = `SADC_FIRST_TRIAL;
            mask_next = `SADC_FIRST_TRIAL;
          end
          else if (tad_reg == `SADC_TAD_LAST)
          begin
            result_next = code_reg;
            done_next   = 1'b1;
            state_next  = sadc_pkg::SADC_IDLE;
          end
          else
          begin
            code_next = (code_reg & ~mask_reg) | (link.comp ? mask_reg : 8'h00) | (mask_reg >> 1);
            mask_next = mask_reg >> 1;
          end
        end
      default:
        state_next = sadc_pkg::SADC_IDLE;
    endcase
    // Abort drops the pending trial bit so unresolved bits show zero
    if (link.abort && state_reg != sadc_pkg::SADC_IDLE)
    begin
      state_next  = sadc_pkg::SADC_IDLE;
      code_next   = code_reg & ~mask_reg;
      mask_next   = `SADC_RST_BYTE;
      result_next = result_reg;
      done_next   = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg  <= sadc_pkg::SADC_IDLE;
      tad_reg    <= 4'h0;
      dly_reg    <= 3'h0;
      code_reg   <= `SADC_RST_BYTE;
      mask_reg   <= `SADC_RST_BYTE;
      result_reg <= `SADC_RST_BYTE;
      done_reg   <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      tad_reg    <= tad_next;
      dly_reg    <= dly_next;
      code_reg   <= code_next;
      mask_reg   <= mask_next;
      result_reg <= result_next;
      done_reg   <= done_next;
    end
  end

  a_rc_start_delay : assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_reg == sadc_pkg::SADC_IDLE && link.start && link.rc_mode) ##1 (!link.abort) [*4]
      |-> (state_reg == sadc_pkg::SADC_DELAY) ##1 (state_reg == sadc_pkg::SADC_CONV)
  ) else $error("rc start not delayed four cycles");

  a_done_after_tad : assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    $rose(done_reg) |-> $past(tad_reg) == `SADC_TAD_LAST
  ) else $error("done before tenth bit period");

endmodule : sadc_sar

// file: core/sadc_top.sv
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ns
`include "sadc_regs.svh"
module sadc_top
(
  input  wire logic       SYS_CLK_IN,
  input  wire logic       RESETN_IN,
  input  wire logic [2:0] REG_ADDR_IN,
  input  wire logic [7:0] REG_WDATA_IN,
  input  wire logic       REG_WR_IN,
  input  wire logic       REG_RD_IN,
  output logic      [7:0] REG_RDATA_OUT,
  input  wire logic       SLEEP_IN,
  input  wire logic       CMP_TRIG_IN,
  input  wire logic       RC_CLK_IN,
  input  wire logic       COMP_IN,
  output logic            CONV_ON_OUT,
  output logic      [3:0] CHANNEL_SEL_OUT,
  output logic      [1:0] REF_SEL_OUT,
  output logic      [7:0] TRIAL_CODE_OUT,
  output logic            CONV_DONE_FLAG_OUT,
  output logic            CONV_IRQ_ENABLE_OUT,
  output logic            WAKE_OUT
);

  // Clock divider terminal count for a clock-select code
  function automatic logic [5:0] tad_last_count(input logic [2:0] sel);
    case (sel)
      3'h0:    tad_last_count = `SADC_DIV2_LAST;
      3'h1:    tad_last_count = `SADC_DIV8_LAST;
      3'h2:    tad_last_count = `SADC_DIV32_LAST;
      3'h4:    tad_last_count = `SADC_DIV4_LAST;
      3'h5:    tad_last_count = `SADC_DIV16_LAST;
      3'h6:    tad_last_count = `SADC_DIV64_LAST;
      default: tad_last_count = `SADC_DIV2_LAST;
    endcase
  endfunction : tad_last_count

  sadc_sar_if sar_link ();

  logic [1:0]           rst_sync_reg;
  logic                 rst_n;
  logic                 rc_meta_reg, rc_sync_reg, rc_prev_reg;
  logic                 converter_on_reg, converter_on_next;
  logic                 go_reg, go_next;
  logic [3:0]           input_channel_select_reg, input_channel_select_next;
  logic [2:0]           conv_clock_select_reg, conv_clock_select_next;
  logic [1:0]           pos_reference_select_reg, pos_reference_select_next;
  sadc_pkg::sadc_byte_t conv_result_reg, conv_result_next;
  logic                 conv_done_flag_reg, conv_done_flag_next;
  logic                 conv_irq_enable_reg, conv_irq_enable_next;
  logic                 sleep_off_reg, sleep_off_next;
  logic                 analog_on_reg, analog_on_next;
  logic                 wake_reg, wake_next;
  logic [5:0]           div_reg, div_next;
  sadc_pkg::sadc_byte_t rdata_reg, rdata_next;

  // Reset release through two flip-flops
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // Pin synchronisers; RC edge is seen only on the second stage
  always_ff @(posedge SYS_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rc_meta_reg   <= 1'b0;
      rc_sync_reg   <= 1'b0;
      rc_prev_reg   <= 1'b0;
    end
    else
    begin
      rc_meta_reg   <= RC_CLK_IN;
      rc_sync_reg   <= rc_meta_reg;
      rc_prev_reg   <= rc_sync_reg;
    end
  end

  // Address and strobe decode
  wire wr_main   = REG_WR_IN && (REG_ADDR_IN == `SADC_OFF_MAIN);
  wire wr_cfg    = REG_WR_IN && (REG_ADDR_IN == `SADC_OFF_CFG);
  wire wr_result = REG_WR_IN && (REG_ADDR_IN == `SADC_OFF_RESULT);
  wire wr_flag   = REG_WR_IN && (REG_ADDR_IN == `SADC_OFF_FLAG);
  wire wd_on     = REG_WDATA_IN[`SADC_MAIN_ON_BIT];
  wire wd_go     = REG_WDATA_IN[`SADC_MAIN_GO_BIT];

  // Clock selection and bit-period tick
  wire rc_mode  = (conv_clock_select_reg[1:0] == `SADC_CLK_RC);
  wire rc_edge  = rc_sync_reg && !rc_prev_reg;
  wire div_tick = (div_reg == tad_last_count(conv_clock_select_reg));
  wire tad_tick = rc_mode ? rc_edge : div_tick;

  // Start and abort causes
  wire sleep_kill  = SLEEP_IN && !rc_mode;
  wire sw_go_set   = wr_main && wd_go && converter_on_reg && wd_on;
  wire trig_set    = CMP_TRIG_IN && converter_on_reg;
  wire start_req   = !go_reg && (sw_go_set || trig_set) && !sleep_kill;
  wire sw_abort    = wr_main && go_reg && (!wd_go || !wd_on);
  wire sleep_abort = sleep_kill && go_reg;
  wire abort_req   = sw_abort || sleep_abort;
  wire conv_done   = sar_link.done;

  // Control side of the engine link
  assign sar_link.start    = start_req;
  assign sar_link.abort    = abort_req;
  assign sar_link.rc_mode  = rc_mode;
  assign sar_link.tad_tick = tad_tick;
  // Comparator follows our registered trial code in a cycle; two flops would go stale at /2
  assign sar_link.comp     = COMP_IN;

  sadc_sar u_sar
  (
    .clk_in   (SYS_CLK_IN),
    .rst_n_in (rst_n),
    .link     (sar_link.sar)
  );

  // Divider restarts while idle so each conversion begins on a full period
  assign div_next = (!sar_link.busy || div_tick) ? 6'h00 : div_reg + 6'h01;

  // Go bit: completion and abort clear it, start requests set it
  always_comb
  begin
    go_next = go_reg;
    if (conv_done)
      go_next = 1'b0;
    else if (abort_req)
      go_next = 1'b0;
    else if (start_req)
      go_next = 1'b1;
  end

  // Register field updates from software writes
  assign converter_on_next         = wr_main ? wd_on : converter_on_reg;
  assign input_channel_select_next = wr_main ?
    REG_WDATA_IN[`SADC_MAIN_CHS_MSB:`SADC_MAIN_CHS_LSB] : input_channel_select_reg;
  assign conv_clock_select_next    = wr_cfg ?
    REG_WDATA_IN[`SADC_CFG_CLK_MSB:`SADC_CFG_CLK_LSB] : conv_clock_select_reg;
  assign pos_reference_select_next = wr_cfg ?
    REG_WDATA_IN[`SADC_CFG_REF_MSB:`SADC_CFG_REF_LSB] : pos_reference_select_reg;
  assign conv_irq_enable_next      = wr_flag ?
    REG_WDATA_IN[`SADC_FLAG_IRQ_EN_BIT] : conv_irq_enable_reg;

  // Result: a finished conversion wins over a software write
  assign conv_result_next = conv_done ? sar_link.result :
                            (wr_result ? REG_WDATA_IN : conv_result_reg);

  // Done flag: hardware set wins over a software clear
  assign conv_done_flag_next = conv_done ||
    (wr_flag ? REG_WDATA_IN[`SADC_FLAG_DONE_BIT] : conv_done_flag_reg);

  // Sleep power-down and wake
  assign sleep_off_next = SLEEP_IN &&
    (sleep_off_reg || !rc_mode || (conv_done && !conv_irq_enable_reg));
  assign analog_on_next = converter_on_next && !sleep_off_next;
  assign wake_next      = conv_done && SLEEP_IN && conv_irq_enable_reg;

  // Read data mux; unimplemented bits and unmapped offsets read zero
  always_comb
  begin
    rdata_next = rdata_reg;
    if (REG_RD_IN)
    begin
      case (REG_ADDR_IN)
        `SADC_OFF_MAIN:   rdata_next = {2'b00, input_channel_select_reg, go_reg,
                                        converter_on_reg};
        `SADC_OFF_CFG:    rdata_next = {1'b0, conv_clock_select_reg, 2'b00,
                                        pos_reference_select_reg};
        `SADC_OFF_RESULT: rdata_next = conv_result_reg;
        `SADC_OFF_FLAG:   rdata_next = {6'h00, conv_irq_enable_reg, conv_done_flag_reg};
        default:          rdata_next = `SADC_RST_BYTE;
      endcase
    end
  end

  // Control and status registers
  always_ff @(posedge SYS_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      converter_on_reg         <= 1'b0;
      go_reg                   <= 1'b0;
      input_channel_select_reg <= 4'h0;
      conv_clock_select_reg    <= 3'h0;
      pos_reference_select_reg <= 2'h0;
      conv_result_reg          <= `SADC_RST_BYTE;
      conv_done_flag_reg       <= 1'b0;
      conv_irq_enable_reg      <= 1'b0;
      sleep_off_reg            <= 1'b0;
      analog_on_reg            <= 1'b0;
      wake_reg                 <= 1'b0;
      div_reg                  <= 6'h00;
      rdata_reg                <= `SADC_RST_BYTE;
    end
    else
    begin
      converter_on_reg         <= converter_on_next;
      go_reg                   <= go_next;
      input_channel_select_reg <= input_channel_select_next;
      conv_clock_select_reg    <= conv_clock_select_next;
      pos_reference_select_reg <= pos_reference_select_next;
      conv_result_reg          <= conv_result_next;
      conv_done_flag_reg       <= conv_done_flag_next;
      conv_irq_enable_reg      <= conv_irq_enable_next;
      sleep_off_reg            <= sleep_off_next;
      analog_on_reg            <= analog_on_next;
      wake_reg                 <= wake_next;
      div_reg                  <= div_next;
      rdata_reg                <= rdata_next;
    end
  end

  // Outputs toward the analog front end and system
  assign REG_RDATA_OUT       = rdata_reg;
  assign CONV_ON_OUT         = analog_on_reg;
  assign CHANNEL_SEL_OUT     = input_channel_select_reg;
  assign REF_SEL_OUT         = pos_reference_select_reg;
  assign TRIAL_CODE_OUT      = sar_link.code;
  assign CONV_DONE_FLAG_OUT  = conv_done_flag_reg;
  assign CONV_IRQ_ENABLE_OUT = conv_irq_enable_reg;
  assign WAKE_OUT            = wake_reg;

  a_done_sets_flag : assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_n)
    conv_done |=> CONV_DONE_FLAG_OUT
  ) else $error("done flag not set at conversion end");

  a_flag_held : assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_n)
    (CONV_DONE_FLAG_OUT && !wr_flag) |=> CONV_DONE_FLAG_OUT
  ) else $error("done flag cleared without software");

  a_done_updates : assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_n)
    conv_done |=> (!go_reg && conv_result_reg == $past(sar_link.result))
  ) else $error("completion did not clear go or load result");

  a_abort_keeps : assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_n)
    (sw_abort && !conv_done && !wr_result) |=> (!go_reg && $stable(conv_result_reg))
  ) else $error("abort changed result or left go set");

  a_off_no_power : assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_n)
    !converter_on_reg |-> !CONV_ON_OUT
  ) else $error("converter powered while disabled");

  a_sleep_kills : assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_n)
    (SLEEP_IN && !rc_mode && go_reg) |=> (!go_reg && !CONV_ON_OUT)
  ) else $error("non-RC sleep did not abort");

  a_trig_starts : assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_n)
    (CMP_TRIG_IN && converter_on_reg && !go_reg && !SLEEP_IN && !wr_main)
      |=> (go_reg && sar_link.busy)
  ) else $error("trigger did not start conversion");

  a_wake_on_done : assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_n)
    (conv_done && SLEEP_IN) |=> (WAKE_OUT == $past(conv_irq_enable_reg))
  ) else $error("wake pulse wrong at completion");

  a_sleep_off_after : assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_n)
    (conv_done && SLEEP_IN && !conv_irq_enable_reg && !wr_main) ##1 SLEEP_IN
      |-> (!CONV_ON_OUT && converter_on_reg)
  ) else $error("converter still powered after sleep completion");

  a_unimpl_zero : assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_n)
    (REG_RD_IN && REG_ADDR_IN == `SADC_OFF_CFG) |=> (REG_RDATA_OUT[7] == 1'b0
      && REG_RDATA_OUT[3:2] == 2'b00)
  ) else $error("unimplemented config bits read nonzero");

  a_busy_shows_go : assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_n)
    sar_link.busy |-> go_reg
  ) else $error("go bit low during conversion");

  a_sw_go_starts : assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_n)
    (sw_go_set && !go_reg && !sleep_kill) |=> (go_reg && sar_link.busy)
  ) else $error("go write did not start conversion");

  a_reset_idle : assert property (
    @(posedge SYS_CLK_IN)
    !rst_n |-> (!go_reg && !CONV_ON_OUT && !sar_link.busy)
  ) else $error("reset left converter active");

  a_rc_sleep_runs : assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_n)
    (SLEEP_IN && rc_mode && go_reg && !conv_done && !sw_abort) |=> go_reg
  ) else $error("RC conversion stopped by sleep");

  a_wake_needs_done : assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_n)
    WAKE_OUT |-> $past(conv_done)
  ) else $error("wake pulse without completion");

  a_done_single : assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_n)
    conv_done |=> !conv_done
  ) else $error("completion pulse longer than one cycle");

  a_result_write : assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_n)
    (wr_result && !conv_done) |=> (conv_result_reg == $past(REG_WDATA_IN))
  ) else $error("software write to result lost");

  a_channel_write : assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_n)
    wr_main |=> (CHANNEL_SEL_OUT == $past(REG_WDATA_IN[`SADC_MAIN_CHS_MSB:`SADC_MAIN_CHS_LSB]))
  ) else $error("channel field not taken from write");

endmodule : sadc_top

// file: test/sadc_afe_model.sv
`timescale 1ns/1ns
// Analog side of the converter: ideal comparator and free-running RC oscillator
module sadc_afe_model
(
  input  wire logic [7:0] level_in,
  input  wire logic [7:0] trial_in,
  output logic            comp_out,
  output logic            rc_clk_out
);
  // Keep the trial bit while the held input is at or above the trial code
  assign comp_out = (level_in >= trial_in);

  // RC oscillator, deliberately unrelated in phase and rate to the system clock
  initial
  begin
    rc_clk_out = 1'b0;
    #7;
    forever #167 rc_clk_out = ~rc_clk_out;
  end
endmodule : sadc_afe_model

// file: test/sadc_top_test.sv
`timescale 1ns/1ns
`include "sadc_regs.svh"
`define CHECK(what, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
    end \
  end
module sadc_top_test;
  logic       clk;
  logic       rst_n;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       sleep;
  logic       trig;
  logic       rc_clk;
  logic       comp;
  logic       conv_on;
  logic [3:0] chan;
  logic [1:0] ref_sel;
  logic [7:0] trial;
  logic       flag;
  logic       irq_en;
  logic       wake;
  logic [7:0] level;
  logic [7:0] rv;
  logic [7:0] last_res;
  int         c;
  int         errors;
  int         cmp_count;
  int         div [8] = '{2, 8, 32, 0, 4, 16, 64, 0};

  // Block under test and its analog partner
  sadc_top uut (.SYS_CLK_IN(clk), .RESETN_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .SLEEP_IN(sleep),
    .CMP_TRIG_IN(trig), .RC_CLK_IN(rc_clk), .COMP_IN(comp), .CONV_ON_OUT(conv_on),
    .CHANNEL_SEL_OUT(chan), .REF_SEL_OUT(ref_sel), .TRIAL_CODE_OUT(trial),
    .CONV_DONE_FLAG_OUT(flag), .CONV_IRQ_ENABLE_OUT(irq_en), .WAKE_OUT(wake));
  sadc_afe_model afe (.level_in(level), .trial_in(trial), .comp_out(comp), .rc_clk_out(rc_clk));

  // System clock, 40 ns period
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  // Bounded wait for the done flag; c returns the cycles spent
  task automatic wait_flag;
    c = 0;
    while (flag !== 1'b1 && c < 4000)
    begin
      @(posedge clk);
      #1;
      c++;
    end
    `CHECK("done flag", 1'b1, flag)
  endtask : wait_flag

  // Configure, power up, settle the input, then set go in a later write
  task automatic start_conv(input logic [7:0] cfg, input logic [3:0] ch);
    wr_reg(`SADC_OFF_CFG, cfg);
    wr_reg(`SADC_OFF_MAIN, {2'b00, ch, 2'b01});
    repeat (8) @(posedge clk);
    wr_reg(`SADC_OFF_MAIN, {2'b00, ch, 2'b11});
  endtask : start_conv

  task automatic reset_dut;
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : reset_dut

  task automatic test_regs;
    rd_reg(`SADC_OFF_MAIN, rv);
    `CHECK("main after reset", 8'h00, rv)
    rd_reg(`SADC_OFF_CFG, rv);
    `CHECK("cfg after reset", 8'h00, rv)
    wr_reg(`SADC_OFF_MAIN, 8'hFD);
    rd_reg(`SADC_OFF_MAIN, rv);
    `CHECK("main loose bits", 8'h3D, rv)
    `CHECK("power enable", 1'b1, conv_on)
    wr_reg(`SADC_OFF_CFG, 8'hFF);
    rd_reg(`SADC_OFF_CFG, rv);
    `CHECK("cfg loose bits", 8'h73, rv)
    for (int i = 0; i < 16; i++)
    begin
      wr_reg(`SADC_OFF_MAIN, {2'b00, i[3:0], 2'b00});
      wr_reg(`SADC_OFF_CFG, {6'h00, i[1:0]});
      rd_reg(`SADC_OFF_CFG, rv);
      `CHECK("channel", i[3:0], chan)
      `CHECK("reference", i[1:0], ref_sel)
    end
    `CHECK("power off", 1'b0, conv_on)
    wr_reg(`SADC_OFF_RESULT, 8'hA5);
    rd_reg(`SADC_OFF_RESULT, rv);
    `CHECK("result rw", 8'hA5, rv)
    rd_reg(3'h5, rv);
    `CHECK("unmapped", 8'h00, rv)
  endtask : test_regs

  task automatic test_clocks;
    for (int k = 0; k < 8; k++)
    begin
      level = 8'h17 + 8'(k * 29);
      start_conv({1'b0, k[2:0], 4'h1}, k[3:0]);
      wait_flag();
      if (div[k] != 0)
        `CHECK("cycles ok", 1'b1, c >= 9 * div[k] + 1 && c <= 10 * div[k] + 4)
      rd_reg(`SADC_OFF_MAIN, rv);
      `CHECK("go after end", {2'b00, k[3:0], 2'b01}, rv)
      rd_reg(`SADC_OFF_RESULT, rv);
      `CHECK("result", level, rv)
      repeat (20) @(posedge clk);
      #1;
      `CHECK("flag held", 1'b1, flag)
      wr_reg(`SADC_OFF_FLAG, 8'h00);
      rd_reg(`SADC_OFF_FLAG, rv);
      `CHECK("flag cleared", 8'h00, rv)
    end
    last_res = level;
  endtask : test_clocks

  task automatic test_abort_trig;
    level = 8'hC3;
    start_conv(8'h60, 4'h2);
    repeat (150) @(posedge clk);
    wr_reg(`SADC_OFF_MAIN, 8'h09);
    rd_reg(`SADC_OFF_MAIN, rv);
    `CHECK("go after abort", 8'h09, rv)
    `CHECK("unresolved bits", 5'h00, trial[4:0])
    rd_reg(`SADC_OFF_RESULT, rv);
    `CHECK("result kept", last_res, rv)
    repeat (700) @(posedge clk);
    #1;
    `CHECK("no flag", 1'b0, flag)
    level = 8'h3C;
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    rd_reg(`SADC_OFF_MAIN, rv);
    `CHECK("go by trigger", 8'h0B, rv)
    wait_flag();
    rd_reg(`SADC_OFF_RESULT, rv);
    `CHECK("trigger result", 8'h3C, rv)
    wr_reg(`SADC_OFF_FLAG, 8'h00);
  endtask : test_abort_trig

  task automatic test_sleep;
    start_conv(8'h60, 4'h0);
    repeat (50) @(posedge clk);
    sleep <= 1'b1;
    rd_reg(`SADC_OFF_MAIN, rv);
    `CHECK("sleep abort", 8'h01, rv)
    `CHECK("sleep power", 1'b0, conv_on)
    @(posedge clk);
    sleep <= 1'b0;
    wr_reg(`SADC_OFF_FLAG, 8'h02);
    level = 8'h81;
    start_conv(8'h30, 4'h0);
    sleep <= 1'b1;
    c = 0;
    while (wake !== 1'b1 && c < 3000)
    begin
      @(posedge clk);
      #1;
      c++;
    end
    `CHECK("wake", 1'b1, wake)
    `CHECK("irq enable", 1'b1, irq_en)
    @(posedge clk);
    sleep <= 1'b0;
    wait_flag();
    rd_reg(`SADC_OFF_RESULT, rv);
    `CHECK("sleep result", 8'h81, rv)
    wr_reg(`SADC_OFF_FLAG, 8'h00);
    start_conv(8'h70, 4'h0);
    sleep <= 1'b1;
    wait_flag();
    rd_reg(`SADC_OFF_MAIN, rv);
    `CHECK("on bit kept", 8'h01, rv)
    `CHECK("off after end", 1'b0, conv_on)
    @(posedge clk);
    sleep <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHECK("on after wake", 1'b1, conv_on)
  endtask : test_sleep

  task automatic test_reset;
    start_conv(8'h60, 4'h1);
    repeat (100) @(posedge clk);
    reset_dut();
    rd_reg(`SADC_OFF_MAIN, rv);
    `CHECK("main reset", 8'h00, rv)
    `CHECK("power reset", 1'b0, conv_on)
    rd_reg(`SADC_OFF_RESULT, rv);
    `CHECK("result reset", 8'h00, rv)
  endtask : test_reset

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    sleep = 1'b0;
    trig = 1'b0;
    level = 8'h00;
    errors = 0;
    cmp_count = 0;
    reset_dut();
    test_regs();
    test_clocks();
    test_abort_trig();
    test_sleep();
    test_reset();
    print_verdict();
  end

  // Watchdog against a hang
  initial
  begin
    #2_000_000;
    errors++;
    print_verdict();
  end
endmodule : sadc_top_test
